// file: hdl/aid_pkg.sv
package aid_pkg;
  // instruction word and operand geometry
  localparam int AID_IW      = 14;
  localparam int AID_DW      = 8;
  localparam int AID_AW      = 7;
  localparam int AID_DEST_BIT = 7;
  localparam int AID_NIB     = 4;
  // opcode patterns in the top six bits
  localparam logic [5:0] AID_OP_ADDLIT = 6'h3E; // 11 111x
  localparam logic [5:0] AID_OP_ANDLIT = 6'h39; // 11 1001
  localparam logic [5:0] AID_OP_ADDREG = 6'h07; // 00 0111
  localparam logic [5:0] AID_OP_ANDREG = 6'h05; // 00 0101
  // reset values
  localparam logic [7:0] AID_ACC_RST  = 8'h00;
  localparam logic       AID_FLAG_RST = 1'b0;
  // one instruction cycle is four clock phases
  localparam int AID_PHASES = 4;

  typedef enum logic [1:0] {
    AID_PH_DECODE  = 2'b00,
    AID_PH_READ    = 2'b01,
    AID_PH_PROCESS = 2'b11,
    AID_PH_WRITE   = 2'b10
  } aid_phase_e;

  typedef enum logic [1:0] {
    AID_OP_NONE = 2'h0,
    AID_OP_ADD  = 2'h1,
    AID_OP_AND  = 2'h2
  } aid_alu_e;
endpackage

// file: hdl/aid_alu_if.sv
`timescale 1ns/10ps
interface aid_alu_if;
  import aid_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  aid_alu_e   op;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       z;
  modport core (output a, b, op, input res, c, dc, z);
  modport alu  (input a, b, op, output res, c, dc, z);
endinterface

// file: hdl/aid_alu.sv
`timescale 1ns/10ps
module aid_alu
  import aid_pkg::*;
(
  aid_alu_if.alu bus // operands in, result and flags out
);
  wire [8:0] sum9;
  wire [4:0] low5;

  assign sum9    = {1'b0, bus.a} + {1'b0, bus.b};
  assign low5    = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
  assign bus.res = (bus.op == AID_OP_AND) ? (bus.a & bus.b) : sum9[7:0];
  assign bus.c   = sum9[8];
  assign bus.dc  = low5[AID_NIB];
  assign bus.z   = (bus.res == 8'h00);
endmodule

// file: hdl/aid_core.sv
`timescale 1ns/10ps
// Function
// RL1 - Add-literal adds the 8-bit immediate to the accumulator, writes it there, updates C, DC and Z.
// RL2 - AND-literal ANDs the accumulator with the immediate into the accumulator, touching only Z.
// RL3 - Add-register adds the accumulator to file register 0..127 and updates C, DC and Z.
// RL4 - AND-register ANDs the accumulator with the file register and touches only Z.
// RL5 - With destination bit 0 the result goes to the accumulator and the register is unchanged.
// RL6 - With destination bit 1 the result goes back to the register and the accumulator is unchanged.
// RL7 - Each instruction takes one word and one cycle of decode, read, process and write phases.
module aid_core
  import aid_pkg::*;
(
  input  wire logic          clk,       // 25 MHz clock
  input  wire logic          rst,       // sync reset, high
  input  wire logic          ce,        // clock enable, freezes all
  input  wire logic [13:0]   instr,     // word, sampled at decode
  input  wire logic          instr_vld, // word offered at decode
  input  wire logic [7:0]    rf_rdata,  // file register read data
  output logic               busy,      // instruction in flight
  output logic [6:0]         rf_addr,   // file register address
  output logic               rf_rd,     // read strobe, read phase
  output logic               rf_wr,     // write strobe, write phase
  output logic [7:0]         rf_wdata,  // write data
  output logic [7:0]         acc,       // accumulator
  output logic               flag_c,    // carry
  output logic               flag_dc,   // digit carry
  output logic               flag_z,    // zero
  output logic               illegal    // last word not handled here
);
  ////////////////////////////////////////////////////////////////////////
  aid_phase_e  phase;
  aid_phase_e  next_phase;
  logic [13:0] ir;
  logic [7:0]  opnd;
  logic [7:0]  res_q;
  logic        rc;
  logic        rdc;
  logic        rz;
  aid_alu_if   alu_bus ();

  aid_alu u_alu (
    .bus (alu_bus)
  );

  wire [5:0] op_hi    = ir[13:8];
  wire       is_addl  = (op_hi[5:1] == AID_OP_ADDLIT[5:1]); // RL1
  wire       is_andl  = (op_hi == AID_OP_ANDLIT);            // RL2
  wire       is_addr  = (op_hi == AID_OP_ADDREG);            // RL3
  wire       is_andr  = (op_hi == AID_OP_ANDREG);            // RL4
  wire       is_reg   = is_addr | is_andr;
  wire       is_add   = is_addl | is_addr;
  wire       is_known = is_add | is_andl | is_andr;
  wire       dest_f   = ir[AID_DEST_BIT];
  wire [5:0] in_hi    = instr[13:8];
  wire       in_ok    = (in_hi[5:1] == AID_OP_ADDLIT[5:1])
                      | (in_hi == AID_OP_ANDLIT)
                      | (in_hi == AID_OP_ADDREG)
                      | (in_hi == AID_OP_ANDREG);
  wire       start    = (phase == AID_PH_DECODE) & instr_vld;

  assign alu_bus.a  = acc;
  assign alu_bus.b  = opnd;
  assign alu_bus.op = is_add ? AID_OP_ADD :
                      ((is_andl | is_andr) ? AID_OP_AND : AID_OP_NONE);

  // the phase ring runs only while a word is in flight
  always_comb begin
    next_phase = phase;
    unique case (phase)
      AID_PH_DECODE:  if (start) next_phase = AID_PH_READ; // RL7
      AID_PH_READ:    next_phase = AID_PH_PROCESS;          // RL7
      AID_PH_PROCESS: next_phase = AID_PH_WRITE;            // RL7
      AID_PH_WRITE:   next_phase = AID_PH_DECODE;           // RL7
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= AID_PH_DECODE;
      ir    <= 14'h0000;
    end else if (ce) begin
      phase <= next_phase;
      if (start) ir <= instr;
    end
  end

  // operand, result and busy/strobe registers
  always_ff @(posedge clk) begin
    if (rst) begin
      opnd    <= 8'h00;
      res_q   <= 8'h00;
      rc      <= 1'b0;
      rdc     <= 1'b0;
      rz      <= 1'b0;
      busy    <= 1'b0;
      rf_addr <= 7'h00;
      rf_rd   <= 1'b0;
      illegal <= 1'b0;
    end else if (ce) begin
      busy  <= (next_phase != AID_PH_DECODE);
      rf_rd <= start & ~instr[13] & in_ok;
      if (start) begin
        rf_addr <= instr[AID_AW-1:0];
        illegal <= ~in_ok;
      end
      if (phase == AID_PH_READ)
        opnd <= is_reg ? rf_rdata : ir[AID_DW-1:0]; // RL1 RL3
      if (phase == AID_PH_PROCESS) begin
        res_q <= alu_bus.res;
        rc    <= alu_bus.c;
        rdc   <= alu_bus.dc;
        rz    <= alu_bus.z;
      end
    end
  end

  wire wr_phase = (phase == AID_PH_WRITE) & is_known;
  wire to_acc   = wr_phase & ~(is_reg & dest_f);       // RL5
  wire to_reg   = wr_phase & is_reg & dest_f;          // RL6

  // results land in the write phase only
  always_ff @(posedge clk) begin
    if (rst) begin
      acc      <= AID_ACC_RST;
      flag_c   <= AID_FLAG_RST;
      flag_dc  <= AID_FLAG_RST;
      flag_z   <= AID_FLAG_RST;
      rf_wr    <= 1'b0;
      rf_wdata <= 8'h00;
    end else if (ce) begin
      rf_wr <= (next_phase == AID_PH_WRITE) & is_reg & dest_f
               & is_known;                              // RL6
      if ((next_phase == AID_PH_WRITE))
        rf_wdata <= alu_bus.res;
      if (to_acc) acc <= res_q;                         // RL5
      if (wr_phase) begin
        flag_z <= rz;                                   // RL2 RL4
        if (is_add) begin
          flag_c  <= rc;                                // RL1 RL3
          flag_dc <= rdc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ce cycles spent on the word in flight, for the length check only
  logic [2:0] busy_len;

  always_ff @(posedge clk) begin
    if (rst)
      busy_len <= 3'h0;
    else if (ce)
      busy_len <= busy ? busy_len + 3'h1 : 3'h0;
  end

  sequence s_take;
    ce && start;
  endsequence
  sequence s_mid;
    (ce && phase == AID_PH_READ) ##1 (ce && phase == AID_PH_PROCESS);
  endsequence

  // phase ring and cycle length
  cycle_ring_a: assert property (@(posedge clk) disable iff (rst) // RL7
    s_take |=> phase == AID_PH_READ)
    else $error("read phase did not follow decode");
  ring_order_a: assert property (@(posedge clk) disable iff (rst) // RL7
    s_take ##1 s_mid |=> phase == AID_PH_WRITE && busy)
    else $error("phases out of order");
  ring_close_a: assert property (@(posedge clk) disable iff (rst) // RL7
    ce && phase == AID_PH_WRITE |=> phase == AID_PH_DECODE && !busy)
    else $error("cycle did not close after write");
  cycle_len_a: assert property (@(posedge clk) disable iff (rst) // RL7
    phase == AID_PH_WRITE |-> busy_len == 3'(AID_PHASES - 2))
    else $error("instruction cycle length wrong");
  // operand and result routing
  rd_strobe_a: assert property (@(posedge clk) disable iff (rst) // RL3 RL4
    rf_rd |-> phase == AID_PH_READ && is_reg)
    else $error("register read outside read phase");
  opnd_take_a: assert property (@(posedge clk) disable iff (rst) // RL3 RL4
    ce && phase == AID_PH_READ && is_reg |=> opnd == $past(rf_rdata))
    else $error("register operand not taken");
  write_back_a: assert property (@(posedge clk) disable iff (rst) // RL5
    (phase == AID_PH_WRITE) && ce && is_known && !(is_reg && dest_f)
      |=> acc == $past(res_q))
    else $error("accumulator not written");
  reg_keep_acc_a: assert property (@(posedge clk) disable iff (rst) // RL6
    (phase == AID_PH_WRITE) && is_reg && dest_f |=> $stable(acc))
    else $error("accumulator changed on register destination");
  reg_strobe_a: assert property (@(posedge clk) disable iff (rst) // RL6
    rf_wr |-> to_reg)
    else $error("register written at wrong time");
  wdata_match_a: assert property (@(posedge clk) disable iff (rst) // RL6
    rf_wr |-> rf_wdata == res_q)
    else $error("register write data differs from result");
  no_reg_wr_a: assert property (@(posedge clk) disable iff (rst) // RL5
    rf_wr |-> !is_addl && !is_andl)
    else $error("literal op wrote file register");
  // flag effects and the literal add result
  and_carry_a: assert property (@(posedge clk) disable iff (rst) // RL2 RL4
    (phase == AID_PH_WRITE) && ce && (is_andl || is_andr)
      |=> $stable(flag_c) && $stable(flag_dc))
    else $error("and changed carry flags");
  andr_zero_a: assert property (@(posedge clk) disable iff (rst) // RL4
    (phase == AID_PH_WRITE) && ce && is_andr
      |=> flag_z == ($past(res_q) == 8'h00))
    else $error("and register zero flag wrong");
  andl_zero_a: assert property (@(posedge clk) disable iff (rst) // RL2
    ce && phase == AID_PH_WRITE && is_andl |=> flag_z == (acc == 8'h00))
    else $error("and literal zero flag wrong");
  add_lit_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (phase == AID_PH_PROCESS) && ce && is_addl
      |-> alu_bus.res == 8'(acc + ir[7:0]))
    else $error("literal add result wrong");
  add_reg_a: assert property (@(posedge clk) disable iff (rst) // RL3
    (phase == AID_PH_PROCESS) && ce && is_addr
      |=> rc == (({1'b0, $past(acc)} + {1'b0, $past(opnd)}) > 9'h0FF))
    else $error("register add carry wrong");
  add_digit_a: assert property (@(posedge clk) disable iff (rst) // RL1 RL3
    ce && phase == AID_PH_PROCESS && is_add
      |=> rdc == (({1'b0, $past(acc[3:0])}
                   + {1'b0, $past(opnd[3:0])}) > 5'h0F))
    else $error("digit carry wrong");
endmodule

// file: sim/aid_rf_model.sv
`timescale 1ns/10ps
module aid_rf_model (
  input  wire logic       clk,      // core clock
  input  wire logic [6:0] rf_addr,  // register address
  input  wire logic       rf_rd,    // read strobe
  input  wire logic       rf_wr,    // write strobe
  input  wire logic [7:0] rf_wdata, // write data
  output logic      [7:0] rf_rdata  // read data
);
  logic [7:0] mem [128];
  logic [7:0] last = 8'h00;
  // idle bus shows inverse of last read, so stale data cannot pass
  assign rf_rdata = rf_rd ? mem[rf_addr] : ~last;
  always @(posedge clk) begin
    if (rf_rd)
      last <= mem[rf_addr];
    if (rf_wr)
      mem[rf_addr] <= rf_wdata;
  end
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
  import aid_pkg::*;
  logic        clk, rst, ce, instr_vld, busy, rf_rd, rf_wr;
  logic        flag_c, flag_dc, flag_z, illegal;
  logic [13:0] instr;
  logic [7:0]  rf_rdata, rf_wdata, acc;
  logic [6:0]  rf_addr;
  int          n_fail, tests_run, n;
  logic [13:0] w [11] = '{14'h3E10, 14'h3F15, 14'h3EFF, 14'h395F, 14'h3900,
    14'h3E17, 14'h0704, 14'h0584, 14'h07FF, 14'h057F, 14'h0000};
  logic [7:0]  ea [11] = '{8'h10, 8'h25, 8'h24, 8'h04, 8'h00, 8'h17, 8'hD9,
    8'hD9, 8'hD9, 8'hC0, 8'hC0};
  logic [2:0]  ef [11] = '{3'h0, 3'h0, 3'h6, 3'h6, 3'h7, 3'h0, 3'h0, 3'h0,
    3'h6, 3'h6, 3'h6};
  logic [7:0]  em [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC2,
    8'hC0, 8'hC2, 8'hC2, 8'h00};

  aid_core dut (.clk, .rst, .ce, .instr, .instr_vld, .rf_rdata, .busy,
    .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .acc, .flag_c, .flag_dc, .flag_z,
    .illegal);
  aid_rf_model rfm (.clk, .rf_addr, .rf_rd, .rf_wr, .rf_wdata, .rf_rdata);

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task summarize;
    $display("mismatches %0d, comparisons %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(negedge clk);
      n++;
    end
  endtask

  // entered at a falling edge
  task issue(input logic [13:0] word);
    instr = word;
    instr_vld = 1'b1;
    @(negedge clk);
    instr_vld = 1'b0;
    wait_idle;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is about 70 cycles
  initial begin
    #20000;
    n_fail++;
    summarize;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    instr = 14'h0000;
    instr_vld = 1'b0;
    n_fail = 0;
    tests_run = 0;
    rfm.mem[7'h04] = 8'hC2;
    rfm.mem[7'h7F] = 8'hE9;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check({acc, busy, flag_c, flag_dc, flag_z, illegal}, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      issue(w[i]);
      check(16'(n), 16'h0003);
      check(acc, ea[i]);
      check({flag_c, flag_dc, flag_z}, ef[i]);
      check(illegal, i == 10);
      if (i > 5 && i < 10)
        check(rfm.mem[w[i][6:0]], em[i]);
    end
    // second word held up while the first is in flight
    instr = 14'h3E0F;
    instr_vld = 1'b1;
    @(negedge clk);
    instr = 14'h393C;
    wait_idle;
    issue(14'h393C);
    check({acc, flag_c, flag_dc, flag_z}, 16'h0060);
    // clock enable low freezes the cycle in flight
    instr = 14'h3E01;
    instr_vld = 1'b1;
    @(negedge clk);
    instr_vld = 1'b0;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check({busy, acc}, 16'h010C);
    ce = 1'b1;
    wait_idle;
    check(acc, 8'h0D);
    // reset in mid-instruction
    instr = 14'h3EF0;
    instr_vld = 1'b1;
    @(negedge clk);
    instr_vld = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({acc, busy, flag_z}, 16'h0000);
    // first word straight after the release
    issue(14'h3E05);
    check(16'(n), 16'h0003);
    check({acc, flag_c, flag_dc, flag_z}, 16'h0028);
    summarize;
  end
endmodule
